// ===== logic/chan_pkg.sv
package chan_pkg;

    // device bus
    localparam int         ADDR_W         = 7;
    localparam int         DATA_W         = 16;
    localparam logic [6:0] FIFO_LAST      = 7'h1F;
    localparam logic [6:0] FIFO_BASE      = 7'h00;
    localparam logic [6:0] STAT_CMD_ADDR  = 7'h20;
    localparam logic [6:0] CNT_LO_ADDR    = 7'h2A;
    localparam logic [6:0] CNT_HI_ADDR    = 7'h2B;
    localparam logic [6:0] IMM_CHAR_ADDR  = 7'h35;

    // status fields
    localparam logic [7:0] STATUS_RESET   = 8'h40;
    localparam int         ST_OVF         = 7;
    localparam int         ST_WEN         = 6;
    localparam int         ST_RXNE        = 5;
    localparam int         ST_FLOW        = 4;
    localparam int         ST_IMM         = 3;
    localparam int         ST_BUSY        = 2;
    localparam int         ST_CTS         = 1;

    // command fields
    localparam int         CMD_SEND       = 3;
    localparam int         CMD_TXRST      = 0;
    localparam logic [7:0] CMD_USED_MASK  = 8'hF9;

    // count high fields
    localparam int         CNTHI_DMA      = 7;
    localparam int         CNT_W          = 12;

    // pool size in bytes, frame length in bits
    localparam logic [6:0] POOL_BYTES     = 7'h20;
    localparam int         FRAME_BITS     = 10;

    // timing
    localparam int         CLK_PERIOD_NS  = 100;
    localparam int         CMD_MAX_TENTHS = 25;
    localparam int         CMD_MAX_CYC    = CMD_MAX_TENTHS / 10;

    // host ahb map
    localparam logic [7:0] H_ADDR_OFF     = 8'h00;
    localparam logic [7:0] H_WDATA_OFF    = 8'h04;
    localparam logic [7:0] H_GO_OFF       = 8'h08;
    localparam logic [7:0] H_RESULT_OFF   = 8'h0C;
    localparam logic [7:0] H_CFG_OFF      = 8'h10;
    localparam logic [7:0] H_SEED_OFF     = 8'h14;
    localparam int         GO_WR          = 0;
    localparam int         GO_RD          = 1;
    localparam int         RES_BUSY       = 8;
    localparam int         RES_XPR        = 9;
    localparam int         RES_DREQ       = 10;
    localparam int         CFG_WORD       = 0;
    localparam int         CFG_DMA        = 1;

    typedef enum logic [2:0] {
        H_IDLE    = 3'b000,
        H_POLL    = 3'b001,
        H_CHECK   = 3'b010,
        H_ACCESS  = 3'b011,
        H_CAPTURE = 3'b100,
        H_DMA     = 3'b101,
        H_GAP     = 3'b110
    } host_state_t;

endpackage

// ===== logic/chan_if.sv
`timescale 1ns/1ns
interface chan_if;
    logic        cs;
    logic        wr;
    logic        rd;
    logic [6:0]  addr;
    logic [15:0] wdata;
    logic        word_mode;
    logic [7:0]  rdata;
    logic        dreq;
    logic        tx_pool_ready_irq;

    modport dev  (input cs, wr, rd, addr, wdata, word_mode, output rdata, dreq, tx_pool_ready_irq);
    modport host (output cs, wr, rd, addr, wdata, word_mode, input rdata, dreq, tx_pool_ready_irq);
endinterface

// ===== logic/chan_dev.sv
// Contract
// - byte or word loads; serial out lsb first
// - host writes at most 32 bytes per pool-ready
// - host programs count before dma transfer
// - odd count in word mode sent exactly
// - dma requests in 32-byte blocks plus remainder
// - whole fifo window selects fifo port
// - overflow set past 32 written bytes
// - overflow cleared by reset or pool move
// - write-enable flag shows fifo accepts data
// - rx-not-empty flag mirrors rx fifo state
// - flow flag one while stopped by xoff
// - immediate pending set on write, until start
// - host waits pending clear before re-access
// - immediate pending at most 2.5 clocks; held here until cts asserted and shifter idle
// - immediate path ignores in-band flow control
// - busy flag while command runs; host waits
// - busy at most 2.5 clocks, except power-down
// - cts bit is inverted cts pin
// - host writes zero to unused command bits; host clears only bits 1 and 2, passing bits 4 to 7 through
// - send starts transmit or dma fetching
// - tx reset flushes, idles line, raises pool-ready
// - command executes within 2.5 clocks
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ns
module chan_dev
    import chan_pkg::*;
#(
    parameter int BAUD_DIV = 16
)(
    // clock and reset
    input  wire logic SYS_CLK_IN,
    input  wire logic RST_IN,
    // parallel bus
    chan_if.dev       BUS,
    // serial and line state
    output logic      TXD_OUT,
    input  wire logic CTS_N_IN,
    input  wire logic RX_NOT_EMPTY_IN,
    input  wire logic FLOW_EN_IN,
    input  wire logic XOFF_SEEN_IN,
    input  wire logic XON_SEEN_IN,
    input  wire logic PWRDN_IN
);

    if (BAUD_DIV < 2 || BAUD_DIV > 65536 || CMD_MAX_CYC < 1) begin : g_chk
        $error("chan_dev: BAUD_DIV must lie in 2 to 65536");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]       mem [0:63];
    logic [5:0]       wr_ptr_r, rd_ptr_r;
    logic [6:0]       acc_cnt_r, sh_cnt_r, blk_left_r;
    logic             commit_r, ovf_r, dma_run_r, dreq_r, xpr_r;
    logic [7:0]       cnt_lo_r, cnt_hi_r, cmd_r, imm_r, rdata_r;
    logic [CNT_W-1:0] dma_left_r;
    logic             cmd_pend_r, tec_r, flow_r, cts_r, rxne_r;
    logic             busy_r, txd_r;
    logic [9:0]       frame_r;
    logic [3:0]       bits_r;
    logic [15:0]      baud_r;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire        wr_any   = BUS.cs && BUS.wr;
    wire        wr_fifo  = wr_any && (BUS.addr <= FIFO_LAST);
    wire        wr_cmd   = wr_any && (BUS.addr == STAT_CMD_ADDR);
    wire        wr_lo    = wr_any && (BUS.addr == CNT_LO_ADDR);
    wire        wr_hi    = wr_any && (BUS.addr == CNT_HI_ADDR);
    wire        wr_imm   = wr_any && (BUS.addr == IMM_CHAR_ADDR);
    wire        rd_stat  = BUS.cs && BUS.rd && (BUS.addr == STAT_CMD_ADDR);
    wire        dma_mode = cnt_hi_r[CNTHI_DMA];
    wire        exec     = cmd_pend_r && !PWRDN_IN;
    wire        send     = exec && cmd_r[CMD_SEND];
    wire        txrst    = exec && cmd_r[CMD_TXRST];
    wire        two      = BUS.word_mode && !(dma_run_r && blk_left_r == 7'h01);
    wire [6:0]  wr_n     = two ? 7'h02 : 7'h01;
    wire        fits     = !commit_r && (acc_cnt_r + wr_n <= POOL_BYTES);
    wire        take     = wr_fifo && fits && !(dma_run_r && blk_left_r == 7'h00);
    wire        over     = wr_fifo && !take;
    wire        move     = commit_r && acc_cnt_r != 7'h00 && sh_cnt_r < POOL_BYTES;
    wire        done     = commit_r && acc_cnt_r == 7'h00;
    wire        line_ok  = cts_r && !busy_r;
    wire        load_imm = line_ok && tec_r;
    wire        load_q   = line_ok && !tec_r && !flow_r && sh_cnt_r != 7'h00;
    wire        tick     = busy_r && baud_r == 16'(BAUD_DIV - 1);
    wire [6:0]  blk_size = (dma_left_r >= CNT_W'(POOL_BYTES)) ? POOL_BYTES : dma_left_r[6:0];
    wire        blk_go   = dma_run_r && !commit_r && blk_left_r == 7'h00
                           && dma_left_r != '0;
    wire        dma_end  = dma_run_r && !commit_r && blk_left_r == 7'h00
                           && dma_left_r == '0;
    wire [7:0]  status   = {ovf_r, !commit_r && acc_cnt_r < POOL_BYTES, rxne_r,
                            flow_r, tec_r, cmd_pend_r, cts_r, 1'b0};

    ////////////////////////////////////////////////////////////////////////////
    // next values
    logic [6:0]       acc_cnt_nxt, sh_cnt_nxt, blk_left_nxt;
    logic [CNT_W-1:0] dma_left_nxt;
    logic             commit_nxt, dma_run_nxt, ovf_nxt;

    always_comb
    begin
        acc_cnt_nxt  = acc_cnt_r + (take ? wr_n : 7'h00) - (move ? 7'h01 : 7'h00);
        sh_cnt_nxt   = sh_cnt_r + (move ? 7'h01 : 7'h00) - (load_q ? 7'h01 : 7'h00);
        blk_left_nxt = blk_left_r;
        dma_left_nxt = dma_left_r;
        commit_nxt   = commit_r && !done;
        dma_run_nxt  = dma_run_r && !dma_end;
        ovf_nxt      = ovf_r && !done;
        if (dma_run_r && take)
        begin
            blk_left_nxt = blk_left_r - wr_n;
            dma_left_nxt = dma_left_r - CNT_W'(wr_n);
            if (blk_left_r == wr_n)
                commit_nxt = 1'b1;
        end
        if (blk_go)
            blk_left_nxt = blk_size;
        if (send && !dma_mode)
            commit_nxt = 1'b1;
        if (send && dma_mode)
        begin
            dma_run_nxt  = 1'b1;
            dma_left_nxt = {cnt_hi_r[3:0], cnt_lo_r};
            blk_left_nxt = 7'h00;
        end
        if (txrst)
        begin
            acc_cnt_nxt  = 7'h00;
            sh_cnt_nxt   = 7'h00;
            blk_left_nxt = 7'h00;
            dma_left_nxt = '0;
            commit_nxt   = 1'b0;
            dma_run_nxt  = 1'b0;
            ovf_nxt      = 1'b0;
        end
        if (over)
            ovf_nxt = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // fifo store and pool counters
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (take)
        begin
            mem[wr_ptr_r] <= BUS.wdata[7:0];
            if (two)
                mem[wr_ptr_r + 6'h01] <= BUS.wdata[15:8];
        end
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN || txrst)
        begin
            wr_ptr_r <= 6'h00;
            rd_ptr_r <= 6'h00;
        end
        else
        begin
            if (take)
                wr_ptr_r <= wr_ptr_r + wr_n[5:0];
            if (load_q)
                rd_ptr_r <= rd_ptr_r + 6'h01;
        end
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
        begin
            acc_cnt_r  <= 7'h00;
            sh_cnt_r   <= 7'h00;
            blk_left_r <= 7'h00;
            dma_left_r <= '0;
            commit_r   <= 1'b0;
            dma_run_r  <= 1'b0;
            ovf_r      <= 1'b0;
            dreq_r     <= 1'b0;
            xpr_r      <= 1'b0;
        end
        else
        begin
            acc_cnt_r  <= acc_cnt_nxt;
            sh_cnt_r   <= sh_cnt_nxt;
            blk_left_r <= blk_left_nxt;
            dma_left_r <= dma_left_nxt;
            commit_r   <= commit_nxt;
            dma_run_r  <= dma_run_nxt;
            ovf_r      <= ovf_nxt;
            dreq_r     <= dma_run_nxt && blk_left_nxt != 7'h00;
            xpr_r      <= txrst || (done && !dma_run_r) || dma_end;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers, command and status
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
        begin
            cnt_lo_r   <= 8'h00;
            cnt_hi_r   <= 8'h00;
            cmd_r      <= 8'h00;
            cmd_pend_r <= 1'b0;
            imm_r      <= 8'h00;
            tec_r      <= 1'b0;
            flow_r     <= 1'b0;
            cts_r      <= 1'b0;
            rxne_r     <= 1'b0;
            rdata_r    <= 8'h00;
        end
        else
        begin
            if (wr_lo)
                cnt_lo_r <= BUS.wdata[7:0];
            if (wr_hi)
                cnt_hi_r <= BUS.wdata[7:0];
            if (wr_cmd && !cmd_pend_r)
            begin
                cmd_r      <= BUS.wdata[7:0];
                cmd_pend_r <= 1'b1;
            end
            else if (exec)
                cmd_pend_r <= 1'b0;
            if (wr_imm)
            begin
                imm_r <= BUS.wdata[7:0];
                tec_r <= 1'b1;
            end
            else if (load_imm)
                tec_r <= 1'b0;
            flow_r  <= FLOW_EN_IN && (XOFF_SEEN_IN || (flow_r && !XON_SEEN_IN));
            cts_r   <= !CTS_N_IN;
            rxne_r  <= RX_NOT_EMPTY_IN;
            rdata_r <= rd_stat ? status : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial shifter, start bit, 8 data lsb first, stop bit
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN || txrst)
        begin
            busy_r  <= 1'b0;
            frame_r <= 10'h3FF;
            bits_r  <= 4'h0;
            baud_r  <= 16'h0000;
            txd_r   <= 1'b1;
        end
        else
        begin
            txd_r <= busy_r ? frame_r[0] : 1'b1;
            if (load_imm || load_q)
            begin
                busy_r  <= 1'b1;
                frame_r <= {1'b1, load_imm ? imm_r : mem[rd_ptr_r], 1'b0};
                bits_r  <= 4'(FRAME_BITS);
                baud_r  <= 16'h0000;
            end
            else if (tick)
            begin
                frame_r <= {1'b1, frame_r[9:1]};
                bits_r  <= bits_r - 4'h1;
                baud_r  <= 16'h0000;
                busy_r  <= bits_r != 4'h1;
            end
            else if (busy_r)
                baud_r <= baud_r + 16'h0001;
        end
    end

    assign TXD_OUT   = txd_r;
    assign BUS.rdata = rdata_r;
    assign BUS.dreq  = dreq_r;
    assign BUS.tx_pool_ready_irq   = xpr_r;

endmodule // chan_dev

// ===== logic/chan_host.sv
`timescale 1ns/1ns
module chan_host
    import chan_pkg::*;
(
    // clock and reset
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_IN,
    // ahb-lite slave
    input  wire logic        HSEL_IN,
    input  wire logic [7:0]  HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic        HREADY_IN,
    output logic      [31:0] HRDATA_OUT,
    output logic             HREADYOUT_OUT,
    output logic             HRESP_OUT,
    // device bus
    chan_if.host             BUS
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    host_state_t st_r, st_nxt;
    logic [6:0]  dev_addr_r, addr_r;
    logic [15:0] dev_wdata_r, seed_r, wdata_r;
    logic [7:0]  result_r, dp_addr_r;
    logic        go_r, go_rd_r, xpr_seen_r, word_r, dma_en_r, dp_wr_r;
    logic        cs_r, wr_r, rd_r;
    logic [31:0] hrdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // ahb decode
    wire        ap      = HSEL_IN && HREADY_IN && HTRANS_IN[1] && HSIZE_IN == 3'h2;
    wire        w_addr  = dp_wr_r && dp_addr_r == H_ADDR_OFF;
    wire        w_wdata = dp_wr_r && dp_addr_r == H_WDATA_OFF;
    wire        w_go    = dp_wr_r && dp_addr_r == H_GO_OFF && !go_r
                          && (HWDATA_IN[GO_WR] || HWDATA_IN[GO_RD]);
    wire        w_res   = dp_wr_r && dp_addr_r == H_RESULT_OFF;
    wire        w_cfg   = dp_wr_r && dp_addr_r == H_CFG_OFF;
    wire        w_seed  = dp_wr_r && dp_addr_r == H_SEED_OFF;
    wire [31:0] res_val = {21'h000000, BUS.dreq, xpr_seen_r, go_r, result_r};
    wire [31:0] rd_val  = (HADDR_IN == H_ADDR_OFF)   ? {25'h0000000, dev_addr_r} :
                          (HADDR_IN == H_WDATA_OFF)  ? {16'h0000, dev_wdata_r} :
                          (HADDR_IN == H_RESULT_OFF) ? res_val :
                          (HADDR_IN == H_CFG_OFF)    ? {30'h00000000, dma_en_r, word_r} :
                          (HADDR_IN == H_SEED_OFF)   ? {16'h0000, seed_r} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // access sequencing
    wire is_cmd   = dev_addr_r == STAT_CMD_ADDR && !go_rd_r;
    wire is_imm   = dev_addr_r == IMM_CHAR_ADDR;
    wire guarded  = is_cmd || is_imm;
    wire hold     = is_imm ? BUS.rdata[ST_IMM] : BUS.rdata[ST_BUSY];
    wire [15:0] cmd_data = dev_wdata_r & {8'h00, CMD_USED_MASK};

    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            H_IDLE:
                if (go_r)
                    st_nxt = guarded ? H_POLL : H_ACCESS;
                else if (dma_en_r && BUS.dreq)
                    st_nxt = H_DMA;
            H_POLL:    st_nxt = H_CHECK;
            H_CHECK:   st_nxt = hold ? H_POLL : H_ACCESS;
            H_ACCESS:  st_nxt = go_rd_r ? H_CAPTURE : H_IDLE;
            H_CAPTURE: st_nxt = H_IDLE;
            H_DMA:     st_nxt = H_GAP;
            H_GAP:     st_nxt = H_IDLE;
            default:   st_nxt = H_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
        begin
            st_r    <= H_IDLE;
            cs_r    <= 1'b0;
            wr_r    <= 1'b0;
            rd_r    <= 1'b0;
            addr_r  <= 7'h00;
            wdata_r <= 16'h0000;
        end
        else
        begin
            st_r    <= st_nxt;
            cs_r    <= st_nxt == H_POLL || st_nxt == H_ACCESS || st_nxt == H_DMA;
            wr_r    <= st_nxt == H_DMA || (st_nxt == H_ACCESS && !go_rd_r);
            rd_r    <= st_nxt == H_POLL || (st_nxt == H_ACCESS && go_rd_r);
            addr_r  <= st_nxt == H_POLL ? STAT_CMD_ADDR :
                       st_nxt == H_DMA  ? FIFO_BASE : dev_addr_r;
            wdata_r <= st_nxt == H_DMA ? seed_r : (is_cmd ? cmd_data : dev_wdata_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ahb registers
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
        begin
            dp_wr_r     <= 1'b0;
            dp_addr_r   <= 8'h00;
            hrdata_r    <= 32'h00000000;
            dev_addr_r  <= 7'h00;
            dev_wdata_r <= 16'h0000;
            go_r        <= 1'b0;
            go_rd_r     <= 1'b0;
            result_r    <= 8'h00;
            xpr_seen_r  <= 1'b0;
            word_r      <= 1'b0;
            dma_en_r    <= 1'b0;
            seed_r      <= 16'h0000;
        end
        else
        begin
            dp_wr_r   <= ap && HWRITE_IN;
            dp_addr_r <= HADDR_IN;
            hrdata_r  <= (ap && !HWRITE_IN) ? rd_val : 32'h00000000;
            if (w_addr)
                dev_addr_r <= HWDATA_IN[6:0];
            if (w_wdata)
                dev_wdata_r <= HWDATA_IN[15:0];
            if (w_cfg)
            begin
                word_r   <= HWDATA_IN[CFG_WORD];
                dma_en_r <= HWDATA_IN[CFG_DMA];
            end
            if (w_go)
            begin
                go_r    <= 1'b1;
                go_rd_r <= HWDATA_IN[GO_RD];
            end
            else if ((st_r == H_ACCESS && !go_rd_r) || st_r == H_CAPTURE)
                go_r <= 1'b0;
            if (st_r == H_CAPTURE)
                result_r <= BUS.rdata;
            if (BUS.tx_pool_ready_irq)
                xpr_seen_r <= 1'b1;
            else if (w_res && HWDATA_IN[RES_XPR])
                xpr_seen_r <= 1'b0;
            if (w_seed)
                seed_r <= HWDATA_IN[15:0];
            else if (st_r == H_DMA)
                seed_r <= seed_r + 16'h0001;
        end
    end

    assign HRDATA_OUT    = hrdata_r;
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT     = 1'b0;
    assign BUS.cs        = cs_r;
    assign BUS.wr        = wr_r;
    assign BUS.rd        = rd_r;
    assign BUS.addr      = addr_r;
    assign BUS.wdata     = wdata_r;
    assign BUS.word_mode = word_r;

endmodule // chan_host

// ===== tb/chan_monitor.sv
`timescale 1ns/1ns
module chan_monitor
    import chan_pkg::*;
(
    // clock and reset
    input wire logic       SYS_CLK_IN,
    input wire logic       RST_IN,
    // device bus
    input wire logic       cs,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [6:0] addr,
    input wire logic [7:0] rdata,
    input wire logic       dreq,
    input wire logic       tx_pool_ready_irq,
    // power-down level
    input wire logic       pwrdn
);
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);

    wire        stat_rd  = cs && rd && addr == STAT_CMD_ADDR;
    wire        cmd_wr   = cs && wr && addr == STAT_CMD_ADDR;
    wire        imm_acc  = cs && addr == IMM_CHAR_ADDR;
    wire        busy_bit = rdata[ST_BUSY];
    wire        imm_bit  = rdata[ST_IMM];
    logic [3:0] since_cmd_r;

    // cycles since last command write or power-down
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (RST_IN)
            since_cmd_r <= 4'hF;
        else if (cmd_wr || pwrdn)
            since_cmd_r <= 4'h0;
        else if (since_cmd_r != 4'hF)
            since_cmd_r <= since_cmd_r + 4'h1;
    end

    ////////////////////////////////////////////////////////////////
    chk_cs_single: assert property (cs |=> !cs)
        else $error("select longer than one cycle");
    chk_strobe_onehot: assert property (cs |-> (wr ^ rd))
        else $error("select without exactly one strobe");
    chk_rdata_quiet: assert property (!(cs && rd) |=> rdata == 8'h00)
        else $error("read data without a read");
    chk_status_zero: assert property (stat_rd |=> !rdata[0])
        else $error("status bit zero set");
    chk_cmd_guard: assert property (cmd_wr |-> $past(stat_rd, 2) && !$past(busy_bit))
        else $error("command written without idle busy flag");
    chk_imm_guard: assert property (imm_acc |-> $past(stat_rd, 2) && !$past(imm_bit))
        else $error("immediate access while pending");
    chk_busy_short: assert property (stat_rd && since_cmd_r >= 4'h2 |=> !busy_bit)
        else $error("busy flag held too long");
    chk_xpr_pulse: assert property (tx_pool_ready_irq |=> !tx_pool_ready_irq)
        else $error("pool ready longer than one cycle");

    cover property (cmd_wr);
    cover property (imm_acc && wr);
    cover property ($rose(dreq));
    cover property (tx_pool_ready_irq);
endmodule // chan_monitor

// ===== tb/async_tx_fifo_status_command_tb.sv
`timescale 1ns/1ns
module async_tx_fifo_status_command_tb
    import chan_pkg::*;
;
    localparam int BAUD = 8;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel, hwrite, cts_n, rxne, flow_en, xoff, xon, pwrdn;
    logic [1:0]  htrans;
    logic [7:0]  haddr, b, c;
    logic [15:0] w;
    logic [31:0] hwdata, r;
    wire  [31:0] hrdata;
    wire         hready, txd;
    int          n_fail, check_count, k;

    always #50 clk = ~clk;
    chan_if bus_if();
    chan_host chan_host_inst (.SYS_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'b010), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(), .BUS(bus_if));
    chan_dev #(.BAUD_DIV(BAUD)) chan_dev_inst (.SYS_CLK_IN(clk), .RST_IN(rst), .BUS(bus_if),
        .TXD_OUT(txd), .CTS_N_IN(cts_n), .RX_NOT_EMPTY_IN(rxne), .FLOW_EN_IN(flow_en),
        .XOFF_SEEN_IN(xoff), .XON_SEEN_IN(xon), .PWRDN_IN(pwrdn));
    chan_monitor chan_monitor_inst (.SYS_CLK_IN(clk), .RST_IN(rst), .cs(bus_if.cs),
        .wr(bus_if.wr), .rd(bus_if.rd), .addr(bus_if.addr), .rdata(bus_if.rdata),
        .dreq(bus_if.dreq), .tx_pool_ready_irq(bus_if.tx_pool_ready_irq), .pwrdn(pwrdn));

    ////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (n_fail == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_rdy();
        int i;
        for (i = 0; i < 100; i++)
        begin
            @(posedge clk);
            if (hready === 1'b1) break;
        end
        if (i == 100)
        begin
            n_fail++;
            close_out();
        end
    endtask

    task automatic ahb(input logic wrt, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wrt;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
    endtask

    // device access through the host, then wait until it is done
    task automatic dev(input int go, input logic [6:0] a, input logic [15:0] d);
        int i;
        ahb(1'b1, H_ADDR_OFF, {25'h0, a});
        ahb(1'b1, H_WDATA_OFF, {16'h0, d});
        ahb(1'b1, H_GO_OFF, 32'h00000001 << go);
        repeat (3) @(posedge clk);
        for (i = 0; i < 200; i++)
        begin
            ahb(1'b0, H_RESULT_OFF, 32'h0);
            if (r[RES_BUSY] === 1'b0) break;
        end
        if (i == 200)
        begin
            n_fail++;
            close_out();
        end
        b = r[7:0];
    endtask

    task automatic rx_byte(output logic [7:0] v);
        int i;
        for (i = 0; i < 4000 && txd !== 1'b0; i++) @(posedge clk);
        if (i == 4000)
        begin
            n_fail++;
            close_out();
        end
        repeat (BAUD / 2) @(posedge clk);
        for (i = 0; i < 8; i++)
        begin
            repeat (BAUD) @(posedge clk);
            v[i] = txd;
        end
        repeat (BAUD) @(posedge clk);
        chk({7'h0, txd}, 8'h01);
    endtask

    task automatic line_idle();
        logic [7:0] z;
        z = 8'h00;
        repeat (12 * BAUD)
        begin
            @(posedge clk);
            if (txd !== 1'b1) z++;
        end
        chk(z, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {rxne, flow_en, xoff, xon, pwrdn} = 5'h00;
        cts_n = 1'b1;
        n_fail = 0;
        check_count = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        dev(GO_RD, STAT_CMD_ADDR, 16'h0);
        chk(b, STATUS_RESET);
        ahb(1'b1, 8'h18, 32'hFFFF);
        ahb(1'b0, 8'h18, 32'h0);
        chk(r[7:0], 8'h00);
        cts_n <= 1'b0;
        rxne <= 1'b1;
        flow_en <= 1'b1;
        xoff <= 1'b1;
        @(posedge clk);
        xoff <= 1'b0;
        dev(GO_RD, STAT_CMD_ADDR, 16'h0);
        chk(b, 8'h72);
        fork
            dev(GO_WR, IMM_CHAR_ADDR, 16'h005A);
            rx_byte(c);
        join
        chk(c, 8'h5A);
        dev(GO_RD, STAT_CMD_ADDR, 16'h0);
        chk(b, 8'h72);
        xon <= 1'b1;
        @(posedge clk);
        xon <= 1'b0;
        dev(GO_RD, STAT_CMD_ADDR, 16'h0);
        chk(b, 8'h62);
        // interrupt mode send, any window offset
        dev(GO_WR, FIFO_LAST, 16'h00A5);
        dev(GO_WR, 7'h05, 16'h003C);
        ahb(1'b1, H_RESULT_OFF, 32'h200);
        fork
            dev(GO_WR, STAT_CMD_ADDR, 16'h0008);
            begin
                rx_byte(c);
                chk(c, 8'hA5);
                rx_byte(c);
                chk(c, 8'h3C);
            end
        join
        ahb(1'b0, H_RESULT_OFF, 32'h0);
        chk({7'h0, r[RES_XPR]}, 8'h01);
        // overflow and transmitter reset
        for (k = 0; k < 32; k++) dev(GO_WR, k[6:0], {8'h0, k[7:0]});
        dev(GO_RD, STAT_CMD_ADDR, 16'h0);
        chk(b & 8'hC0, 8'h00);
        dev(GO_WR, FIFO_BASE, 16'h00EE);
        dev(GO_RD, STAT_CMD_ADDR, 16'h0);
        chk(b & 8'hC0, 8'h80);
        ahb(1'b1, H_RESULT_OFF, 32'h200);
        dev(GO_WR, STAT_CMD_ADDR, 16'h0001);
        dev(GO_RD, STAT_CMD_ADDR, 16'h0);
        chk(b & 8'hC0, 8'h40);
        chk({7'h0, r[RES_XPR]}, 8'h01);
        // command held busy in power-down
        pwrdn <= 1'b1;
        dev(GO_WR, STAT_CMD_ADDR, 16'h0010);
        dev(GO_RD, STAT_CMD_ADDR, 16'h0);
        chk(b & 8'h04, 8'h04);
        pwrdn <= 1'b0;
        dev(GO_RD, STAT_CMD_ADDR, 16'h0);
        chk(b & 8'h04, 8'h00);
        line_idle();
        // dma, word access, odd count of 35
        ahb(1'b1, H_CFG_OFF, 32'h3);
        ahb(1'b1, H_SEED_OFF, 32'h1200);
        dev(GO_WR, CNT_LO_ADDR, 16'h0023);
        dev(GO_WR, CNT_HI_ADDR, 16'h0080);
        ahb(1'b1, H_RESULT_OFF, 32'h200);
        fork
            dev(GO_WR, STAT_CMD_ADDR, 16'h0008);
            for (k = 0; k < 35; k++)
            begin
                rx_byte(c);
                w = 16'h1200 + 16'(k / 2);
                chk(c, k[0] ? w[15:8] : w[7:0]);
            end
        join
        line_idle();
        ahb(1'b0, H_RESULT_OFF, 32'h0);
        chk({6'h0, r[RES_DREQ], r[RES_XPR]}, 8'h01);
        close_out();
    end
endmodule // async_tx_fifo_status_command_tb
